/* File: shared/sru_map.vh */
// sru_map.vh: address map, command fields, flag positions and op codes
// of the shift/rotate unit; definitions only, included by bare name.
`ifndef SRU_MAP_VH
`define SRU_MAP_VH

// avalon byte offsets of the control registers
`define SRU_OFF_CMD 8'h00
`define SRU_OFF_FLAGS 8'h04
`define SRU_OFF_ACC 8'h08
// register pairs: address[7:5] == this, index in address[4:2]
`define SRU_RF_TAG 3'h2
// operand memory: address[7:6] == this, index in address[5:2]
`define SRU_MEM_TAG 2'h2

// command word fields
`define SRU_CMD_OP 2:0
`define SRU_CMD_CNT 6:4
`define SRU_CMD_SEL 11:8
`define SRU_CMD_PAIR 10:8
`define SRU_CMD_W 12
`define SRU_CMD_BPAIR 11:9
`define SRU_CMD_HI 8
`define SRU_CMD_BODY 11:0
`define SRU_CMD_ISSUED 1'h1

// bus address fields: pair tag, memory tag, memory and pair index
`define SRU_ADR_RF 7:5
`define SRU_ADR_MEM 7:6
`define SRU_ADR_MIDX 5:2
`define SRU_ADR_RIDX 4:2

// operation codes
`define SRU_OP_RRC 3'h0
`define SRU_OP_RLC 3'h1
`define SRU_OP_LRB 3'h2
`define SRU_OP_LLB 3'h3
`define SRU_OP_LRW 3'h4
`define SRU_OP_LLW 3'h5
`define SRU_OP_NRR 3'h6
`define SRU_OP_NRL 3'h7

// flag register bit positions; other bits reserved, read zero
`define SRU_F_CARRY 0
`define SRU_F_PV 2
`define SRU_F_NIBC 4
`define SRU_F_Z 6
`define SRU_F_S 7
`define SRU_FLAG_MASK 8'hD5

// reset values
`define SRU_RST_FLAGS 8'h00
`define SRU_RST_ACC 8'h00
`define SRU_RST_WORD 16'h0000
`define SRU_RST_CMD 13'h0000

`endif

/* File: rtl/sru_mem.v */
// sru_mem: 16-byte operand memory for the nibble rotates.
// assumes one port, read data registered every clock.
`timescale 1ns/10ps
module sru_mem (
  // clock
  input wire mclk_i,
  // access port
  input wire [3:0] addr_i,
  input wire we_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o
);
  reg [7:0] mem_reg [0:15];

  // read-before-write: the old byte comes out on a write cycle
  always @(posedge mclk_i) begin
    rdata_o <= mem_reg[addr_i];
    if (we_i) begin
      mem_reg[addr_i] <= wdata_i;
    end
  end
endmodule // sru_mem

/* File: rtl/sru_step.v */
// sru_step: one step of a shift or rotate, purely combinational.
// assumes byte ops carry their operand in d_i[7:0].
`timescale 1ns/10ps
`include "sru_map.vh"
module sru_step (
  // operation
  input wire [2:0] op_i,
  input wire [15:0] d_i,
  input wire cin_i,
  // result
  output reg [15:0] q_o,
  output reg cout_o
);
  always @* begin
    q_o = d_i;
    cout_o = cin_i;
    case (op_i)
      `SRU_OP_RRC: begin
        q_o = {8'h00, cin_i, d_i[7:1]};
        cout_o = d_i[0];
      end
      `SRU_OP_RLC: begin
        q_o = {8'h00, d_i[6:0], cin_i};
        cout_o = d_i[7];
      end
      `SRU_OP_LRB: begin
        q_o = {8'h00, 1'h0, d_i[7:1]};
        cout_o = d_i[0];
      end
      `SRU_OP_LLB: begin
        q_o = {8'h00, d_i[6:0], 1'h0};
        cout_o = d_i[7];
      end
      `SRU_OP_LRW: begin
        q_o = {1'h0, d_i[15:1]};
        cout_o = d_i[0];
      end
      `SRU_OP_LLW: begin
        q_o = {d_i[14:0], 1'h0};
        cout_o = d_i[15];
      end
      default: begin
        q_o = d_i;
        cout_o = cin_i;
      end
    endcase
  end
endmodule // sru_step

/* File: rtl/sru_core.v */
// sru_core: shift/rotate execution unit with its own register pairs,
// accumulator, flag register and operand memory, reached over an
// avalon-mm slave with waitrequest. assumes a single master that holds
// each request until it samples waitrequest low.
// Behaviour
// - rotate right through carry, count 0-7
// - rotate left through carry, count 0-7
// - zero count changes neither destination nor flags; nibble rotates ignore the count and always run
// - byte ops set parity flag on even ones
// - carry rotates keep sign, zero, nibble carry
// - right shifts feed zero into top bit
// - right shifts clear sign flag
// - shifts set zero flag from whole result
// - shifts force nibble carry flag clear
// - left shifts feed zero, carry gets top
// - byte left shift: sign is bit 7
// - word left shift: sign is bit 15
// - word shifts: parity over low byte only
// - right shifts: carry is last bit out
// - word shifts use 16-bit pair, count 0-7
// - right nibble rotate through accumulator and memory
// - left nibble rotate through accumulator and memory
// - nibble rotates keep accumulator upper nibble
// - nibble memory byte addressed by register pair
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`include "sru_map.vh"
module sru_core (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // avalon-mm slave
  input wire [7:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] writedata_i,
  input wire [3:0] byteenable_i,
  output reg [31:0] readdata_o,
  output reg waitrequest_o,
  // state views
  output reg [7:0] flags_o,
  output reg [7:0] acc_o
);
  localparam ST_IDLE = 6'h01;
  localparam ST_STEP = 6'h02;
  localparam ST_NIB = 6'h04;
  localparam ST_BRD = 6'h08;
  localparam ST_ACK = 6'h10;
  localparam ST_HOLD = 6'h20;

  reg [5:0] state_reg;
  reg [12:0] cmd_reg;
  reg [7:0] flags_reg;
  reg [7:0] acc_reg;
  reg [15:0] rf_reg [0:7];
  reg [15:0] wk_reg;
  reg carry_reg;
  reg [2:0] cnt_reg;
  reg [3:0] nib_addr_reg;
  integer i;

  wire [15:0] step_q;
  wire step_c;
  wire [7:0] mem_q;
  reg [3:0] mem_addr;
  reg mem_we;
  reg [7:0] mem_wd;

  // bus decode
  wire req = (read_i | write_i) & waitrequest_o & (state_reg == ST_IDLE);
  wire hit_rf = (address_i[`SRU_ADR_RF] == `SRU_RF_TAG);
  wire hit_mem = (address_i[`SRU_ADR_MEM] == `SRU_MEM_TAG);
  wire [2:0] op = cmd_reg[`SRU_CMD_OP];
  wire [2:0] new_op = writedata_i[`SRU_CMD_OP];
  wire [3:0] new_sel = writedata_i[`SRU_CMD_SEL];
  wire [2:0] new_pair = writedata_i[`SRU_CMD_PAIR];
  wire new_cmd = req & write_i & (address_i == `SRU_OFF_CMD);

  // byte-enable merge, used for register pair writes only
  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0] be;
    begin
      merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                 be[0] ? new_v[7:0] : old_v[7:0]};
    end
  endfunction

  // byte register n lives in pair n/2, odd n is the high byte
  function [7:0] pick_byte;
    input [15:0] w;
    input hi;
    begin
      pick_byte = hi ? w[15:8] : w[7:0];
    end
  endfunction

  function [15:0] put_byte;
    input [15:0] w;
    input hi;
    input [7:0] b;
    begin
      put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
    end
  endfunction

  function is_nibble;
    input [2:0] o;
    begin
      is_nibble = (o == `SRU_OP_NRR) | (o == `SRU_OP_NRL);
    end
  endfunction

  function is_word;
    input [2:0] o;
    begin
      is_word = (o == `SRU_OP_LRW) | (o == `SRU_OP_LLW);
    end
  endfunction

  sru_step u_step (
    .op_i(op),
    .d_i(wk_reg),
    .cin_i(carry_reg),
    .q_o(step_q),
    .cout_o(step_c)
  );

  sru_mem u_mem (
    .mclk_i(mclk_i),
    .addr_i(mem_addr),
    .we_i(mem_we),
    .wdata_i(mem_wd),
    .rdata_o(mem_q)
  );

  // nibble rotate results from the fetched byte
  reg [7:0] nib_acc;
  reg [7:0] nib_mem;
  always @* begin
    if (op == `SRU_OP_NRR) begin
      nib_acc = {acc_reg[7:4], mem_q[3:0]};
      nib_mem = {acc_reg[3:0], mem_q[7:4]};
    end else begin
      nib_acc = {acc_reg[7:4], mem_q[7:4]};
      nib_mem = {mem_q[3:0], acc_reg[3:0]};
    end
  end

  // operand memory port: nibble write-back wins, then fetch, then bus
  always @* begin
    mem_addr = address_i[`SRU_ADR_MIDX];
    mem_we = 1'h0;
    mem_wd = writedata_i[7:0];
    if (state_reg == ST_NIB) begin
      mem_addr = nib_addr_reg;
      mem_we = 1'h1;
      mem_wd = nib_mem;
    end else if (new_cmd) begin
      mem_addr = rf_reg[new_pair][3:0];
    end else if (req & write_i & hit_mem) begin
      mem_we = byteenable_i[0];
    end
  end

  // flags after the last step; rotates keep sign, zero, nibble carry
  reg [7:0] fl_done;
  always @* begin
    fl_done = flags_reg;
    fl_done[`SRU_F_CARRY] = step_c;
    if (op == `SRU_OP_RRC || op == `SRU_OP_RLC) begin
      fl_done[`SRU_F_PV] = ~^step_q[7:0];
    end else begin
      fl_done[`SRU_F_PV] = ~^step_q[7:0];
      fl_done[`SRU_F_NIBC] = 1'h0;
      if (is_word(op)) begin
        fl_done[`SRU_F_Z] = (step_q == 16'h0000);
      end else begin
        fl_done[`SRU_F_Z] = (step_q[7:0] == 8'h00);
      end
      if (op == `SRU_OP_LRB || op == `SRU_OP_LRW) begin
        fl_done[`SRU_F_S] = 1'h0;
      end else if (op == `SRU_OP_LLW) begin
        fl_done[`SRU_F_S] = step_q[15];
      end else begin
        fl_done[`SRU_F_S] = step_q[7];
      end
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cmd_reg <= `SRU_RST_CMD;
      flags_reg <= `SRU_RST_FLAGS;
      acc_reg <= `SRU_RST_ACC;
      wk_reg <= `SRU_RST_WORD;
      carry_reg <= 1'h0;
      cnt_reg <= 3'h0;
      nib_addr_reg <= 4'h0;
      readdata_o <= 32'h00000000;
      waitrequest_o <= 1'h1;
      flags_o <= `SRU_RST_FLAGS;
      acc_o <= `SRU_RST_ACC;
      for (i = 0; i < 8; i = i + 1) begin
        rf_reg[i] <= `SRU_RST_WORD;
      end
    end else begin
      flags_o <= flags_reg;
      acc_o <= acc_reg;
      case (state_reg)
        ST_IDLE: begin
          if (req) begin
            readdata_o <= 32'h00000000;
            state_reg <= ST_ACK;
            waitrequest_o <= 1'h0;
            if (write_i) begin
              if (address_i == `SRU_OFF_CMD) begin
                cmd_reg <= {`SRU_CMD_ISSUED, writedata_i[`SRU_CMD_BODY]};
                carry_reg <= flags_reg[`SRU_F_CARRY];
                cnt_reg <= writedata_i[`SRU_CMD_CNT];
                if (is_nibble(new_op)) begin
                  // byte fetched this edge, rewritten next cycle
                  nib_addr_reg <= rf_reg[new_pair][3:0];
                  state_reg <= ST_NIB;
                  waitrequest_o <= 1'h1;
                end else if (writedata_i[`SRU_CMD_CNT] != 3'h0) begin
                  if (is_word(new_op)) begin
                    wk_reg <= rf_reg[new_pair];
                  end else begin
                    wk_reg <= {8'h00,
                      pick_byte(rf_reg[new_sel[3:1]], new_sel[0])};
                  end
                  state_reg <= ST_STEP;
                  waitrequest_o <= 1'h1;
                end
                // zero count: answered at once, only the command register and step state loaded
              end else if (address_i == `SRU_OFF_FLAGS) begin
                // reserved bits are never stored, so they read zero
                flags_reg <= byteenable_i[0] ?
                  (writedata_i[7:0] & `SRU_FLAG_MASK) : flags_reg;
              end else if (address_i == `SRU_OFF_ACC) begin
                acc_reg <= byteenable_i[0] ? writedata_i[7:0] : acc_reg;
              end else if (hit_rf) begin
                rf_reg[address_i[`SRU_ADR_RIDX]] <= merge16(
                  rf_reg[address_i[`SRU_ADR_RIDX]],
                  writedata_i[15:0], byteenable_i[1:0]);
              end
              // unmapped writes are answered and dropped
            end else begin
              if (address_i == `SRU_OFF_CMD) begin
                readdata_o <= {19'h00000, cmd_reg};
              end else if (address_i == `SRU_OFF_FLAGS) begin
                readdata_o <= {24'h000000, flags_reg};
              end else if (address_i == `SRU_OFF_ACC) begin
                readdata_o <= {24'h000000, acc_reg};
              end else if (hit_rf) begin
                readdata_o <= {16'h0000, rf_reg[address_i[`SRU_ADR_RIDX]]};
              end else if (hit_mem) begin
                // memory data arrive one edge later
                state_reg <= ST_BRD;
                waitrequest_o <= 1'h1;
              end
            end
          end
        end
        ST_STEP: begin
          // one bit per clock keeps the shifter a single stage
          wk_reg <= step_q;
          carry_reg <= step_c;
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            flags_reg <= fl_done;
            if (is_word(op)) begin
              rf_reg[cmd_reg[`SRU_CMD_PAIR]] <= step_q;
            end else begin
              rf_reg[cmd_reg[`SRU_CMD_BPAIR]] <= put_byte(
                rf_reg[cmd_reg[`SRU_CMD_BPAIR]],
                cmd_reg[`SRU_CMD_HI], step_q[7:0]);
            end
            state_reg <= ST_ACK;
            waitrequest_o <= 1'h0;
          end
        end
        ST_NIB: begin
          acc_reg <= nib_acc; // flags untouched
          state_reg <= ST_ACK;
          waitrequest_o <= 1'h0;
        end
        ST_BRD: begin
          state_reg <= ST_HOLD;
        end
        ST_HOLD: begin
          readdata_o <= {24'h000000, mem_q};
          state_reg <= ST_ACK;
          waitrequest_o <= 1'h0;
        end
        ST_ACK: begin
          // master takes the answer at this edge
          waitrequest_o <= 1'h1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
          waitrequest_o <= 1'h1;
        end
      endcase
    end
  end
endmodule // sru_core

/* File: tb/sru_core_sva.sv */
// sru_core_sva: bus timing and flag checks on the unit's ports.
// assumes a master that drops its request for a cycle between transfers.
`timescale 1ns/10ps
`include "sru_map.vh"
module sru_core_sva (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // avalon-mm slave
  input wire [7:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] writedata_i,
  input wire [3:0] byteenable_i,
  input wire [31:0] readdata_o,
  input wire waitrequest_o,
  // state views
  input wire [7:0] flags_o,
  input wire [7:0] acc_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  reg wr_d;
  reg rd_d;
  always @(posedge mclk_i) begin
    wr_d <= write_i;
    rd_d <= read_i;
  end
  // request edges, seen without sampled-value functions
  wire cmd_go = write_i && !wr_d && address_i == `SRU_OFF_CMD;
  wire nib = writedata_i[2:1] == 2'h3;
  wire zcnt = writedata_i[6:4] == 3'h0;
  wire rd_go = read_i && !rd_d;
  wire acc_wr = write_i && address_i == `SRU_OFF_ACC;

  a_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low too long");
  a_idle_no_answer: assert property (!read_i && !write_i |=> waitrequest_o)
    else $error("answer without request");
  a_reset_state: assert property ($fell(rst_i) |->
    waitrequest_o && flags_o == 8'h00 && acc_o == 8'h00)
    else $error("state not cleared by reset");
  a_flag_reserved: assert property ((flags_o & ~`SRU_FLAG_MASK) == 8'h00)
    else $error("reserved flag bit set");
  a_zero_count: assert property (cmd_go && zcnt && !nib |=>
    !waitrequest_o && $stable(flags_o) ##1 $stable(flags_o)[*2])
    else $error("zero count answer or flags wrong");
  a_nib_answer: assert property (cmd_go && nib |=>
    waitrequest_o ##1 !waitrequest_o)
    else $error("nibble rotate answer late");
  a_nib_flags: assert property (cmd_go && nib |=> $stable(flags_o)[*4])
    else $error("nibble rotate changed flags");
  a_shift_seven: assert property (cmd_go && writedata_i[6:4] == 3'h7
    && !nib |=> waitrequest_o[*7] ##1 !waitrequest_o)
    else $error("seven step answer time wrong");
  a_reg_answer: assert property ((rd_go || write_i && !wr_d)
    && address_i != `SRU_OFF_CMD && address_i[7:6] != 2'h2
    |=> !waitrequest_o)
    else $error("register access answer late");
  a_mem_read: assert property (rd_go && address_i[7:6] == 2'h2 |=>
    waitrequest_o[*2] ##1 !waitrequest_o)
    else $error("memory read answer time wrong");
  a_acc_upper: assert property ($changed(acc_o[7:4]) |->
    $past(acc_wr, 2))
    else $error("accumulator upper nibble changed");

  c_nibble: cover property (cmd_go && nib);
  c_seven: cover property (cmd_go && writedata_i[6:4] == 3'h7);
  c_memrd: cover property (rd_go && address_i[7:6] == 2'h2);
endmodule // sru_core_sva

bind sru_core sru_core_sva u_sru_core_sva (
  .mclk_i(mclk_i), .rst_i(rst_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
  .byteenable_i(byteenable_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .flags_o(flags_o), .acc_o(acc_o)
);

/* File: tb/sru_bfm.sv */
// sru_bfm: avalon-mm master standing in for the core decoder.
// assumes one clock; each call starts right after a rising edge.
`timescale 1ns/10ps
module sru_bfm (
  // clock
  input wire mclk_i,
  // avalon-mm master
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o,
  input wire [31:0] readdata_i,
  input wire waitrequest_i
);
  initial begin
    {address_o, read_o, write_o, writedata_o} = '0;
    byteenable_o = 4'hF;
  end
  // lanes hold until the next call; only called between transfers
  task automatic set_be(input logic [3:0] b);
    byteenable_o <= b;
  endtask
  // random idle gap: the decoder is sometimes slow to issue
  task automatic xfer(input logic we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    repeat ($urandom % 2) @(posedge mclk_i);
    address_o <= a;
    writedata_o <= d;
    write_o <= we;
    read_o <= !we;
    do @(posedge mclk_i); while (waitrequest_i !== 1'b0);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    @(posedge mclk_i);
  endtask
endmodule // sru_bfm

/* File: tb/tb_top.sv */
// tb_top: random commands checked against a reference model.
// assumes the master model sru_bfm and the bound checker.
`timescale 1ns/10ps
`include "sru_map.vh"
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  wire [7:0] address_i;
  wire read_i;
  wire write_i;
  wire [31:0] writedata_i;
  wire [3:0] byteenable_i;
  wire [31:0] readdata_o;
  wire waitrequest_o;
  wire [7:0] flags_o;
  wire [7:0] acc_o;
  logic [31:0] e_rd;
  logic [31:0] exp_q[$];
  int checks = 0;
  int n_mismatch = 0;
  logic [2:0] op, cnt;
  logic [3:0] sel, k;
  logic [7:0] ef, ea, em, pa;
  logic [15:0] ev, w;
  logic [31:0] cmd;
  logic c;
  int it, i;

  always #5 mclk_i = ~mclk_i;

  sru_bfm u_sru_bfm (
    .mclk_i(mclk_i), .address_o(address_i), .read_o(read_i),
    .write_o(write_i), .writedata_o(writedata_i),
    .byteenable_o(byteenable_i), .readdata_i(readdata_o),
    .waitrequest_i(waitrequest_o)
  );
  sru_core u_sru_core (
    .mclk_i(mclk_i), .rst_i(rst_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .flags_o(flags_o), .acc_o(acc_o)
  );

  task automatic cmp(input logic [31:0] e);
    checks++;
    if (readdata_o !== e) begin
      n_mismatch++;
      $display("ERROR readdata expected %h seen %h", e, readdata_o);
    end
  endtask
  task automatic cmp_view(input string n, input logic [7:0] e,
      input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_sru_bfm.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    u_sru_bfm.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // read answers only stand at the edge where waitrequest is low
  // the views lag their registers by a clock, long settled by then
  always @(posedge mclk_i) begin
    if (!rst_i && read_i && waitrequest_o === 1'b0) begin
      e_rd = exp_q.pop_front();
      cmp(e_rd);
      if (address_i == `SRU_OFF_FLAGS)
        cmp_view("flags_o", e_rd[7:0], flags_o);
      if (address_i == `SRU_OFF_ACC)
        cmp_view("acc_o", e_rd[7:0], acc_o);
    end
  end

  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(90));
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(`SRU_OFF_FLAGS, 32'h0);
    rd(`SRU_OFF_ACC, 32'h0);
    rd(8'h40, 32'h0);
    rd(`SRU_OFF_CMD, 32'h0);
    wr(8'h3C, $urandom);
    rd(8'h3C, 32'h0);
    // single-lane write keeps the other byte of the pair
    wr(8'h44, 32'h0000A5C3);
    u_sru_bfm.set_be(4'h2);
    wr(8'h44, 32'h00001E2D);
    u_sru_bfm.set_be(4'hF);
    rd(8'h44, 32'h00001EC3);
    for (it = 0; it < 40; it++) begin
      op = it[2:0];
      cnt = it < 8 ? 3'h0 : it < 16 ? 3'h7 : 3'($urandom);
      sel = 4'($urandom);
      ev = 16'($urandom);
      ea = 8'($urandom);
      em = 8'($urandom);
      ef = 8'($urandom) & `SRU_FLAG_MASK;
      pa = {3'h2, op > 3 ? sel[2:0] : sel[3:1], 2'h0};
      k = ev[3:0];
      wr(pa, {16'h0, ev});
      wr({2'h2, k, 2'h0}, {24'h0, em});
      wr(`SRU_OFF_ACC, {24'h0, ea});
      wr(`SRU_OFF_FLAGS, {24'h0, ef | 8'h2A});
      cmd = {20'h0, sel, 1'b0, cnt, 1'b0, op};
      wr(`SRU_OFF_CMD, cmd);
      c = ef[0];
      w = op > 3 ? ev : {8'h0, sel[0] ? ev[15:8] : ev[7:0]};
      for (i = 0; i < cnt && op < 6; i++)
        case (op)
          3'h0: {w[7:0], c} = {c, w[7:0]};
          3'h1: {c, w[7:0]} = {w[7:0], c};
          3'h2: {w[7:0], c} = {1'b0, w[7:0]};
          3'h3: {c, w[7:0]} = {w[7:0], 1'b0};
          3'h4: {w, c} = {1'b0, w};
          default: {c, w} = {w, 1'b0};
        endcase
      if (op > 5)
        {ea[3:0], em} = op[0] ? {em, ea[3:0]}
          : {em[3:0], ea[3:0], em[7:4]};
      else if (cnt != 3'h0) begin
        ef[0] = c;
        ef[2] = ~^w[7:0];
        // carry rotates leave sign, zero, nibble carry
        if (op > 1) begin
          ef[4] = 1'b0;
          ef[6] = w == 16'h0;
          ef[7] = op == 3 ? w[7] : op == 5 && w[15];
        end
        if (op > 3)
          ev = w;
        else if (sel[0])
          ev[15:8] = w[7:0];
        else
          ev[7:0] = w[7:0];
      end
      rd(pa, {16'h0, ev});
      rd({2'h2, k, 2'h0}, {24'h0, em});
      rd(`SRU_OFF_ACC, {24'h0, ea});
      rd(`SRU_OFF_FLAGS, {24'h0, ef});
      rd(`SRU_OFF_CMD, {19'h0, 1'b1, cmd[11:0]});
    end
    repeat (2) @(posedge mclk_i);
    tally_and_finish();
  end
endmodule // tb_top
